// >>> rtl/usart_sync_serial.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// What this block does
// - reception starts only after a receive enable
// - data sampled on shift clock falling edge
// - single enable receives one word, stops
// - continuous enable receives until cleared
// - both enables set means continuous reception
// - completed word sets flag, irq if enabled
// - clearing continuous enable clears receive errors
// - clock source cleared means external shift clock
// - slave mode works during low power
// - second queued word waits, empty flag clear
// - second word loaded, then empty flag set
// - buffer empty event raises wake interrupt
// - slave ignores single enable, else like master
// - continuous receive works in low power
// - word received in low power interrupts
// - transmit buffer write starts transmission
// - master mode drives shift clock on pin
// - empty flag clears only by buffer write
// - shift register empty bit reads one when idle
module usart_sync_serial (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // shift clock pin
  input  wire logic        SHIFT_CLOCK_PIN_IN,
  output logic             SHIFT_CLOCK_PIN_OUT,
  output logic             SHIFT_CLOCK_PIN_OE,
  // data pin, two-way in clocked mode
  input  wire logic        RECEIVE_DATA_PIN_IN,
  output logic             RECEIVE_DATA_PIN_OUT,
  output logic             RECEIVE_DATA_PIN_OE,
  // interrupt request
  output logic             IRQ
);

  // stored control bits
  logic        serial_port_enable;         // port on
  logic        nine_bit_receive_select;    // 9-bit receive
  logic        single_receive_enable;      // one word then stop
  logic        continuous_receive_enable;  // receive until cleared
  logic        addr_detect;                // stored only
  logic        overrun_error_flag;         // word lost
  logic        receive_ninth_bit;          // ninth bit of last word
  logic        clock_source_master_select; // master drives clock
  logic        nine_bit_transmit_select;   // 9-bit transmit
  logic        transmitter_enable;         // transmit on
  logic        sync_mode;                  // clocked mode
  logic        send_break;                 // stored only
  logic        high_rate;                  // stored only
  logic        transmit_ninth_bit;         // ninth bit to send
  logic [7:0]  baud_control;               // polarity and width
  logic [7:0]  divisor_high;               // upper divisor byte
  logic [7:0]  divisor_low;                // lower divisor byte
  logic [7:0]  interrupt_enables;          // enable bits
  logic [7:0]  interrupt_priorities;       // stored only
  // data path
  logic [7:0]  receive_buffer;             // last received byte
  logic        receive_complete_flag;      // buffer holds word
  logic [7:0]  transmit_buffer;            // queued byte
  logic        tx_full;                    // transmit buffer loaded
  logic [8:0]  transmit_shift_register;    // outgoing bits
  logic [8:0]  receive_shift_register;     // incoming bits
  logic [3:0]  bit_cnt;                    // bits done in word
  usart_sync_pkg::engine_state_t state;    // engine state
  // master clock generator
  logic [15:0] div_cnt;                    // half period counter
  logic        ck_lvl;                     // logical clock level
  // pin synchronisers
  logic        ck_s1, ck_s2, ck_s3;        // clock pin stages
  logic        dt_s1, dt_s2;               // data pin stages

  // decoded helpers
  logic        port_on;      // port enabled in clocked mode
  logic        rx_on;        // receive requested
  logic        pol;          // clock idle polarity
  logic [15:0] divisor;      // effective divisor
  logic        tick;         // half period elapsed
  logic        fall;         // shift clock falling edge
  logic [3:0]  last_bit;     // index of last receive bit
  logic [3:0]  last_tx_bit;  // index of last transmit bit
  logic [8:0]  next_rsr;     // shift register after sample
  logic        word_done;    // received word complete
  logic [7:0]  word_data;    // received data byte
  logic        word_ninth;   // received ninth bit
  logic        tx_load;      // buffer moves into shift register
  logic        access;       // apb access completes
  logic        wr_en;        // completing write
  logic        rd_en;        // completing read
  logic        mapped;       // address decodes
  logic [7:0]  rd_byte;      // read mux
  logic        wr_flags, wr_ien, wr_prio, wr_rxs;
  logic        wr_txs, wr_baud, wr_divh, wr_divl, wr_txb;
  logic        rd_rxb;

  // mode decode
  always_comb begin
    port_on  = serial_port_enable & sync_mode;
    // continuous wins, single only in master mode
    rx_on    = port_on & (continuous_receive_enable |
               (single_receive_enable & clock_source_master_select));
    pol      = baud_control[usart_sync_pkg::BIT_CLK_POL];
    divisor  = baud_control[usart_sync_pkg::BIT_WIDE_DIV] ?
               {divisor_high, divisor_low} : {8'h00, divisor_low};
    last_bit = nine_bit_receive_select ? usart_sync_pkg::LAST_BIT_9 :
               usart_sync_pkg::LAST_BIT_8;
    last_tx_bit = nine_bit_transmit_select ? usart_sync_pkg::LAST_BIT_9 :
                  usart_sync_pkg::LAST_BIT_8;
  end

  // edge selection: own clock in master, pin clock in slave
  always_comb begin
    tick = clock_source_master_select && (state != usart_sync_pkg::ST_IDLE)
           && (div_cnt == divisor);
    if (clock_source_master_select) begin
      fall = tick & ck_lvl;
    end else begin // external clock
      fall = ((ck_s3 ^ pol) & ~(ck_s2 ^ pol));
    end
  end

  // received word assembly, lsb first
  always_comb begin
    next_rsr  = {dt_s2, receive_shift_register[8:1]};
    word_done = (state == usart_sync_pkg::ST_RX) && rx_on && fall &&
                (bit_cnt == last_bit);
    if (nine_bit_receive_select) begin
      word_data  = next_rsr[7:0];
      word_ninth = next_rsr[8];
    end else begin
      word_data  = next_rsr[8:1];
      word_ninth = 1'b0;
    end
  end

  // buffer to shift register transfer
  always_comb begin
    tx_load = 1'b0;
    if (port_on && transmitter_enable && !rx_on && tx_full) begin
      if (state == usart_sync_pkg::ST_IDLE) begin
        tx_load = 1'b1;
      end else if (state == usart_sync_pkg::ST_TX && fall &&
                   bit_cnt == last_tx_bit) begin
        tx_load = 1'b1;
      end
    end
  end

  // apb strobes and address decode
  always_comb begin
    access   = PSEL & PENABLE & PREADY;
    wr_en    = access & PWRITE;
    rd_en    = access & ~PWRITE;
    wr_flags = 1'b0;
    wr_ien   = 1'b0;
    wr_prio  = 1'b0;
    wr_rxs   = 1'b0;
    wr_txs   = 1'b0;
    wr_baud  = 1'b0;
    wr_divh  = 1'b0;
    wr_divl  = 1'b0;
    wr_txb   = 1'b0;
    rd_rxb   = 1'b0;
    mapped   = 1'b1;
    rd_byte  = 8'h00;
    if (PADDR == usart_sync_pkg::OFF_INT_FLAGS) begin
      wr_flags = wr_en;
      rd_byte[usart_sync_pkg::BIT_RX_EVENT] = receive_complete_flag;
      rd_byte[usart_sync_pkg::BIT_TX_EVENT] = ~tx_full;
    end else if (PADDR == usart_sync_pkg::OFF_INT_ENABLES) begin
      wr_ien  = wr_en;
      rd_byte = interrupt_enables;
    end else if (PADDR == usart_sync_pkg::OFF_INT_PRIOS) begin
      wr_prio = wr_en;
      rd_byte = interrupt_priorities;
    end else if (PADDR == usart_sync_pkg::OFF_RX_STATUS) begin
      wr_rxs  = wr_en;
      rd_byte = {serial_port_enable, nine_bit_receive_select,
                 single_receive_enable, continuous_receive_enable,
                 addr_detect, 1'b0, overrun_error_flag,
                 receive_ninth_bit};
    end else if (PADDR == usart_sync_pkg::OFF_RX_BUFFER) begin
      rd_rxb  = rd_en;
      rd_byte = receive_buffer;
    end else if (PADDR == usart_sync_pkg::OFF_TX_STATUS) begin
      wr_txs  = wr_en;
      rd_byte = {clock_source_master_select, nine_bit_transmit_select,
                 transmitter_enable, sync_mode, send_break, high_rate,
                 ~(state == usart_sync_pkg::ST_TX),
                 transmit_ninth_bit};
    end else if (PADDR == usart_sync_pkg::OFF_BAUD_CTRL) begin
      wr_baud = wr_en;
      rd_byte = baud_control;
    end else if (PADDR == usart_sync_pkg::OFF_DIV_HIGH) begin
      wr_divh = wr_en;
      rd_byte = divisor_high;
    end else if (PADDR == usart_sync_pkg::OFF_DIV_LOW) begin
      wr_divl = wr_en;
      rd_byte = divisor_low;
    end else if (PADDR == usart_sync_pkg::OFF_TX_BUFFER) begin
      wr_txb  = wr_en;
      rd_byte = transmit_buffer;
    end else begin
      mapped  = 1'b0;
    end
  end

  // apb answer, one wait state
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // pin synchronisers, three stages for the clock pin, two for the data pin
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end else begin
      ck_s1 <= SHIFT_CLOCK_PIN_IN;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= RECEIVE_DATA_PIN_IN;
      dt_s2 <= dt_s1;
    end
  end

  // receive status and control, hardware clears single enable
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      serial_port_enable        <= 1'b0;
      nine_bit_receive_select   <= 1'b0;
      single_receive_enable     <= 1'b0;
      continuous_receive_enable <= 1'b0;
      addr_detect               <= 1'b0;
      overrun_error_flag        <= 1'b0;
    end else begin
      if (wr_rxs) begin
        serial_port_enable        <= PWDATA[usart_sync_pkg::BIT_PORT_EN];
        nine_bit_receive_select   <= PWDATA[usart_sync_pkg::BIT_RX9_SEL];
        single_receive_enable     <= PWDATA[usart_sync_pkg::BIT_SINGLE_RX];
        continuous_receive_enable <= PWDATA[usart_sync_pkg::BIT_CONT_RX];
        addr_detect               <= PWDATA[usart_sync_pkg::BIT_ADDR_DET];
      end else if (word_done && !continuous_receive_enable) begin
        single_receive_enable <= 1'b0; // one word only
      end
      // overrun set wins over the clear
      if (word_done && receive_complete_flag && !rd_rxb) begin
        overrun_error_flag <= 1'b1;
      end else if (wr_rxs && !PWDATA[usart_sync_pkg::BIT_CONT_RX]) begin
        overrun_error_flag <= 1'b0;
      end
    end
  end

  // transmit control, baud and enable registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      clock_source_master_select <= 1'b0;
      nine_bit_transmit_select   <= 1'b0;
      transmitter_enable         <= 1'b0;
      sync_mode                  <= 1'b0;
      send_break                 <= 1'b0;
      high_rate                  <= 1'b0;
      transmit_ninth_bit         <= 1'b0;
      baud_control               <= usart_sync_pkg::RST_BYTE;
      divisor_high               <= usart_sync_pkg::RST_DIV[15:8];
      divisor_low                <= usart_sync_pkg::RST_DIV[7:0];
      interrupt_enables          <= usart_sync_pkg::RST_BYTE;
      interrupt_priorities       <= usart_sync_pkg::RST_BYTE;
    end else begin
      if (wr_txs) begin
        clock_source_master_select <= PWDATA[usart_sync_pkg::BIT_MASTER];
        nine_bit_transmit_select   <= PWDATA[usart_sync_pkg::BIT_TX9_SEL];
        transmitter_enable         <= PWDATA[usart_sync_pkg::BIT_TX_EN];
        sync_mode                  <= PWDATA[usart_sync_pkg::BIT_SYNC_MODE];
        send_break                 <= PWDATA[usart_sync_pkg::BIT_SEND_BRK];
        high_rate                  <= PWDATA[usart_sync_pkg::BIT_HIGH_RATE];
        transmit_ninth_bit         <= PWDATA[usart_sync_pkg::BIT_TX_NINTH];
      end
      if (wr_baud) begin
        baud_control <= PWDATA[7:0];
      end
      if (wr_divh) begin
        divisor_high <= PWDATA[7:0];
      end
      if (wr_divl) begin
        divisor_low <= PWDATA[7:0];
      end
      if (wr_ien) begin
        interrupt_enables <= PWDATA[7:0];
      end
      if (wr_prio) begin
        interrupt_priorities <= PWDATA[7:0];
      end
    end
  end

  // receive buffer and completion flag, set wins over read clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      receive_buffer        <= 8'h00;
      receive_ninth_bit     <= 1'b0;
      receive_complete_flag <= 1'b0;
    end else begin
      if (word_done && (!receive_complete_flag || rd_rxb)) begin
        receive_buffer        <= word_data;
        receive_ninth_bit     <= word_ninth;
        receive_complete_flag <= 1'b1;
      end else if (rd_rxb) begin
        receive_complete_flag <= 1'b0;
      end
    end
  end

  // transmit buffer, emptiness is the buffer-empty flag
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      transmit_buffer <= 8'h00;
      tx_full         <= 1'b0;
    end else begin
      if (wr_txb) begin
        transmit_buffer <= PWDATA[7:0];
        tx_full         <= 1'b1; // only a write clears the flag
      end else if (tx_load) begin
        tx_full <= 1'b0; // second word waits until now
      end
    end
  end

  // master shift clock generator
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      div_cnt <= 16'h0000;
      ck_lvl  <= 1'b0;
    end else if (!clock_source_master_select ||
                 state == usart_sync_pkg::ST_IDLE) begin
      div_cnt <= 16'h0000;
      ck_lvl  <= 1'b0;
    end else if (tick) begin
      div_cnt <= 16'h0000;
      ck_lvl  <= ~ck_lvl;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // shift engine, receive overrides transmit
  always_ff @(posedge CLOCK) begin
    if (RST || !port_on) begin
      state                   <= usart_sync_pkg::ST_IDLE;
      bit_cnt                 <= 4'h0;
      transmit_shift_register <= 9'h000;
      receive_shift_register  <= 9'h000;
    end else begin
      case (state)
        usart_sync_pkg::ST_IDLE: begin
          bit_cnt <= 4'h0;
          if (rx_on) begin
            state <= usart_sync_pkg::ST_RX;
          end else if (tx_load) begin
            transmit_shift_register <= {transmit_ninth_bit,
                                        transmit_buffer};
            state <= usart_sync_pkg::ST_TX;
          end
        end
        usart_sync_pkg::ST_RX: begin
          if (!rx_on) begin
            state <= usart_sync_pkg::ST_IDLE; // enable cleared
          end else if (fall) begin
            receive_shift_register <= next_rsr;
            if (bit_cnt == last_bit) begin
              bit_cnt <= 4'h0; // next word back to back
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        usart_sync_pkg::ST_TX: begin
          if (rx_on || !transmitter_enable) begin
            state <= usart_sync_pkg::ST_IDLE;
          end else if (fall) begin
            if (bit_cnt == last_tx_bit) begin
              bit_cnt <= 4'h0;
              if (tx_load) begin
                transmit_shift_register <= {transmit_ninth_bit,
                                            transmit_buffer};
              end else begin
                state <= usart_sync_pkg::ST_IDLE;
              end
            end else begin
              transmit_shift_register <= {1'b0,
                                          transmit_shift_register[8:1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= usart_sync_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // registered pin drivers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SHIFT_CLOCK_PIN_OUT  <= 1'b0;
      SHIFT_CLOCK_PIN_OE   <= 1'b0;
      RECEIVE_DATA_PIN_OUT <= 1'b0;
      RECEIVE_DATA_PIN_OE  <= 1'b0;
    end else begin
      SHIFT_CLOCK_PIN_OUT  <= ck_lvl ^ pol;
      SHIFT_CLOCK_PIN_OE   <= port_on & clock_source_master_select;
      RECEIVE_DATA_PIN_OUT <= transmit_shift_register[0];
      RECEIVE_DATA_PIN_OE  <= (state == usart_sync_pkg::ST_TX);
    end
  end

  // interrupt request, works with no activity on the bus
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (receive_complete_flag &
              interrupt_enables[usart_sync_pkg::BIT_RX_EVENT]) |
             (~tx_full & interrupt_enables[usart_sync_pkg::BIT_TX_EVENT]);
    end
  end

endmodule // usart_sync_serial

// >>> pkg/usart_sync_pkg.sv
package usart_sync_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_INT_FLAGS   = 8'h00;
  localparam logic [7:0] OFF_INT_ENABLES = 8'h04;
  localparam logic [7:0] OFF_INT_PRIOS   = 8'h08;
  localparam logic [7:0] OFF_RX_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_RX_BUFFER   = 8'h10;
  localparam logic [7:0] OFF_TX_STATUS   = 8'h14;
  localparam logic [7:0] OFF_BAUD_CTRL   = 8'h18;
  localparam logic [7:0] OFF_DIV_HIGH    = 8'h1c;
  localparam logic [7:0] OFF_DIV_LOW     = 8'h20;
  localparam logic [7:0] OFF_TX_BUFFER   = 8'h24;

  // interrupt flag and enable bit positions
  localparam int BIT_RX_EVENT = 5;
  localparam int BIT_TX_EVENT = 4;

  // receive status and control bit positions
  localparam int BIT_PORT_EN   = 7;
  localparam int BIT_RX9_SEL   = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX   = 4;
  localparam int BIT_ADDR_DET  = 3;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVERRUN   = 1;
  localparam int BIT_RX_NINTH  = 0;

  // transmit status and control bit positions
  localparam int BIT_MASTER    = 7;
  localparam int BIT_TX9_SEL   = 6;
  localparam int BIT_TX_EN     = 5;
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_SEND_BRK  = 3;
  localparam int BIT_HIGH_RATE = 2;
  localparam int BIT_TSR_EMPTY = 1;
  localparam int BIT_TX_NINTH  = 0;

  // baud control bit positions
  localparam int BIT_CLK_POL  = 4;
  localparam int BIT_WIDE_DIV = 3;

  // reset values of the stored registers
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_DIV    = 16'h0000;

  // last bit index of an 8-bit and a 9-bit word
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  // engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TX   = 3'b010,
    ST_RX   = 3'b100
  } engine_state_t;

endpackage

// >>> dv/usart_sync_serial_props.sv
`timescale 1ns/1ps
// bus handshake and pin checks, top ports only
module usart_sync_serial_props (
  // clock, reset and apb
  input wire logic        CLOCK, RST, PSEL, PENABLE, PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  input wire logic        PREADY, PSLVERR,
  // serial pins and interrupt
  input wire logic        SHIFT_CLOCK_PIN_IN, SHIFT_CLOCK_PIN_OUT,
  input wire logic        SHIFT_CLOCK_PIN_OE, RECEIVE_DATA_PIN_IN,
  input wire logic        RECEIVE_DATA_PIN_OUT, RECEIVE_DATA_PIN_OE,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // exactly one wait state, then a one-cycle ready
  a_ready_wait: assert property (PSEL && $rose(PENABLE) |->
    !PREADY ##1 PREADY) else $error("ready not in second access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside an access phase");
  // error marks only unmapped or unaligned places
  a_err_decode: assert property (PREADY |-> PSLVERR == (PADDR[1:0] != 2'h0
    || PADDR > usart_sync_pkg::OFF_TX_BUFFER))
    else $error("slave error does not match address decode");
  a_err_rdata: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read returned data");
  a_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_hold: assert property (!PREADY |-> $stable(PRDATA))
    else $error("read data moved outside a completion");
  // outputs quiet right after a reset cycle
  a_reset_quiet: assert property (disable iff (1'b0) RST |=> !PREADY
    && !IRQ && !RECEIVE_DATA_PIN_OE && !SHIFT_CLOCK_PIN_OE)
    else $error("outputs active after reset");
  // slave send: data steady while the outside clock is high
  a_tx_hold: assert property (RECEIVE_DATA_PIN_OE && !SHIFT_CLOCK_PIN_OE
    && $rose(SHIFT_CLOCK_PIN_IN) |-> ##2 $stable(RECEIVE_DATA_PIN_OUT)[*2])
    else $error("transmit data changed while shift clock high");
endmodule // usart_sync_serial_props

bind usart_sync_serial usart_sync_serial_props u_props (
  .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
  .SHIFT_CLOCK_PIN_IN(SHIFT_CLOCK_PIN_IN),
  .SHIFT_CLOCK_PIN_OUT(SHIFT_CLOCK_PIN_OUT),
  .SHIFT_CLOCK_PIN_OE(SHIFT_CLOCK_PIN_OE),
  .RECEIVE_DATA_PIN_IN(RECEIVE_DATA_PIN_IN),
  .RECEIVE_DATA_PIN_OUT(RECEIVE_DATA_PIN_OUT),
  .RECEIVE_DATA_PIN_OE(RECEIVE_DATA_PIN_OE));

// >>> dv/sync_peer_model.sv
`timescale 1ns/1ps
// outside serial peer: slave shift clock and data
module sync_peer_model (
  // system clock and resolved lines
  input  wire logic clock,
  input  wire logic line_clk,
  input  wire logic line_data,
  // what the peer drives
  output logic      peer_clk,
  output logic      peer_data
);
  // clock idles low between frames
  initial begin
    peer_clk = 1'b0;
    peer_data = 1'b1;
  end
  // wait whole system cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one frame at 320 ns: data set on rise, line read before each fall
  task automatic frame(input logic [8:0] w, input int nb,
                       output logic [8:0] got);
    got = 9'h0;
    for (int i = 0; i < nb; i++) begin
      tick(1);
      peer_clk <= 1'b1;
      peer_data <= w[i];
      tick(4);
      got[i] = line_data;
      peer_clk <= 1'b0;
      tick(3);
    end
    tick(1);
    peer_data <= ~peer_data; // released: show the inverse
  endtask
  // feed a clock master: next bit after each falling edge
  task automatic feed(input logic [8:0] w, input int nb);
    peer_data <= w[0];
    for (int i = 1; i <= nb; i++) begin
      @(negedge line_clk);
      tick(1);
      peer_data <= (i < nb) ? w[i] : ~w[nb-1];
    end
  endtask
endmodule // sync_peer_model

// >>> dv/test_usart_sync_serial.sv
`timescale 1ns/1ps
// register level test of the clocked serial port
module test_usart_sync_serial;
  logic        clock, rst, psel, penable, pwrite, pclk, pdat, er;
  logic        pready, pslverr, ck_out, ck_oe, dt_out, dt_oe, irq;
  logic [7:0]  paddr;
  logic [8:0]  got;
  logic [31:0] pwdata, prdata, rv;
  int          n_mismatch = 0;
  int          checked = 0;
  wire ck_line = ck_oe ? ck_out : pclk; // resolved shift clock
  wire dt_line = dt_oe ? dt_out : pdat; // resolved data line
  usart_sync_serial dut (.CLOCK(clock), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SHIFT_CLOCK_PIN_IN(ck_line), .SHIFT_CLOCK_PIN_OUT(ck_out),
    .SHIFT_CLOCK_PIN_OE(ck_oe), .RECEIVE_DATA_PIN_IN(dt_line),
    .RECEIVE_DATA_PIN_OUT(dt_out), .RECEIVE_DATA_PIN_OE(dt_oe), .IRQ(irq));
  sync_peer_model peer (.clock(clock), .line_clk(ck_line),
    .line_data(dt_line), .peer_clk(pclk), .peer_data(pdat));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // masked compare
  task automatic chk(input logic [31:0] g, e, m);
    checked++;
    if ((g & m) !== (e & m)) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1); // watchdog ends a hang
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 8'h0);
    chk(rv, e, m);
  endtask
  // poll the flag register until a bit sets, the watchdog bounds it
  task automatic wflag(input int b);
    do apb(1'b0, usart_sync_pkg::OFF_INT_FLAGS, 8'h0);
    while (rv[b] !== 1'b1);
    chk(rv, 32'h1 << b, 32'h1 << b);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(usart_sync_pkg::OFF_INT_FLAGS, 32'h10, 32'hff);
    rd(usart_sync_pkg::OFF_TX_STATUS, 32'h02, 32'hff);
    apb(1'b0, 8'h28, 8'h0);
    chk({31'h0, er}, 32'h1, 32'h1);
    chk(rv, 32'h0, 32'hffffffff);
    // master single receive
    wr(usart_sync_pkg::OFF_DIV_LOW, 8'h03);
    wr(usart_sync_pkg::OFF_TX_STATUS, 8'h90);
    wr(usart_sync_pkg::OFF_RX_STATUS, 8'h80);
    wr(usart_sync_pkg::OFF_INT_ENABLES, 8'h20);
    fork peer.feed(9'h05a, 8); join_none
    wr(usart_sync_pkg::OFF_RX_STATUS, 8'ha0);
    wflag(5);
    chk({31'h0, irq}, 32'h1, 32'h1);
    rd(usart_sync_pkg::OFF_RX_STATUS, 32'h80, 32'hf0);
    rd(usart_sync_pkg::OFF_RX_BUFFER, 32'h5a, 32'hff);
    repeat (100) @(posedge clock);
    rd(usart_sync_pkg::OFF_INT_FLAGS, 32'h0, 32'h20);
    // slave, both enables, 9 bits, then overrun
    wr(usart_sync_pkg::OFF_TX_STATUS, 8'h10);
    wr(usart_sync_pkg::OFF_RX_STATUS, 8'hf0);
    peer.frame(9'h1a5, 9, got);
    wflag(5);
    chk({31'h0, irq}, 32'h1, 32'h1);
    peer.frame(9'h0c3, 9, got);
    repeat (8) @(posedge clock);
    rd(usart_sync_pkg::OFF_RX_STATUS, 32'hf3, 32'hdf);
    rd(usart_sync_pkg::OFF_RX_BUFFER, 32'ha5, 32'hff);
    wr(usart_sync_pkg::OFF_RX_STATUS, 8'h80);
    rd(usart_sync_pkg::OFF_RX_STATUS, 32'h80, 32'hfe);
    // slave with only the single enable: nothing is received
    wr(usart_sync_pkg::OFF_RX_STATUS, 8'ha0);
    peer.frame(9'h0ff, 8, got);
    repeat (8) @(posedge clock);
    rd(usart_sync_pkg::OFF_INT_FLAGS, 32'h0, 32'h20);
    wr(usart_sync_pkg::OFF_RX_STATUS, 8'h80);
    // slave send of two queued 9-bit words, ninth bit set first
    wr(usart_sync_pkg::OFF_INT_ENABLES, 8'h10);
    wr(usart_sync_pkg::OFF_TX_STATUS, 8'h71);
    wr(usart_sync_pkg::OFF_TX_BUFFER, 8'h3c);
    wr(usart_sync_pkg::OFF_TX_BUFFER, 8'hc3);
    rd(usart_sync_pkg::OFF_INT_FLAGS, 32'h0, 32'h10);
    rd(usart_sync_pkg::OFF_TX_STATUS, 32'h0, 32'h02);
    chk({31'h0, irq}, 32'h0, 32'h1);
    peer.frame(9'h0, 9, got);
    chk({23'h0, got}, 32'h13c, 32'h1ff);
    repeat (4) @(posedge clock);
    rd(usart_sync_pkg::OFF_INT_FLAGS, 32'h10, 32'h10);
    chk({31'h0, irq}, 32'h1, 32'h1);
    wr(usart_sync_pkg::OFF_INT_FLAGS, 8'h00);
    rd(usart_sync_pkg::OFF_INT_FLAGS, 32'h10, 32'h10);
    peer.frame(9'h0, 9, got);
    chk({23'h0, got}, 32'h1c3, 32'h1ff);
    repeat (8) @(posedge clock);
    rd(usart_sync_pkg::OFF_TX_STATUS, 32'h02, 32'h02);
    tally_and_finish;
  end
endmodule // test_usart_sync_serial
